// ===== hw/sib_pkg.sv
package sib_pkg;

   // register indices; byte address is four times the index
   localparam logic [15:0] SIB_IDX_BUF = 16'h7f63;
   localparam logic [15:0] SIB_IDX_PCNT = 16'h7f68;
   localparam logic [15:0] SIB_IDX_MODE = 16'h7f69;
   localparam logic [15:0] SIB_IDX_PINS = 16'h7f6a;
   localparam logic [15:0] SIB_IDX_STAT = 16'h7f6b;

   // serial_port_control fields
   localparam int SIB_PC_HOLD = 3;
   localparam int SIB_PC_VOLT = 2;
   localparam int SIB_PC_THR = 1;
   localparam int SIB_PC_SLOW = 0;

   // mode register fields
   localparam int SIB_MODE_SEL = 7;
   localparam int SIB_MODE_SPEED = 5;
   localparam int SIB_MODE_DIV_MSB = 4;

   // pin configuration nibbles {func a, func b, latch, direction}
   localparam int SIB_PIN_CLK_LSB = 0;
   localparam int SIB_PIN_DATA_LSB = 4;
   localparam int SIB_PIN_DOUT_LSB = 8;
   localparam logic [3:0] SIB_PIN_OPEN = 4'hf;
   localparam logic [3:0] SIB_PIN_CMOS = 4'h9;
   localparam logic [3:0] SIB_PIN_SLOW = 4'he;
   localparam logic [3:0] SIB_PIN_OD = 4'hd;

   // scl period multipliers
   localparam logic [8:0] SIB_MULT_STD = 9'h008;
   localparam logic [8:0] SIB_MULT_FAST = 9'h002;

   // bit counter landmarks
   localparam logic [3:0] SIB_BIT_LAST_RISE = 4'h7;
   localparam logic [3:0] SIB_BIT_BYTE = 4'h8;
   localparam logic [3:0] SIB_BIT_ACK = 4'h9;

   // values after reset
   localparam logic [7:0] SIB_BUF_RST = 8'h00;
   localparam logic [3:0] SIB_PCNT_RST = 4'h0;
   localparam logic [11:0] SIB_PINS_RST = 12'hfff;

   function automatic logic regHit(input logic [17:0] addr, input logic [15:0] idx);
      return addr == {idx, 2'b00};
   endfunction

endpackage

// ===== hw/sib_sync.sv
`timescale 1ns/10ps

module sib_sync (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // asynchronous levels in, synchronised levels out
   input wire logic [1:0] din,
   output logic [1:0] dout
);

   typedef struct packed {
      logic [1:0] stage1;
      logic [1:0] stage2;
   } sib_sync_t;

   sib_sync_t s;
   sib_sync_t next_s;

   always_comb begin
      next_s.stage1 = din;
      next_s.stage2 = s.stage1;
      if (!rst_n) begin
         // both lines idle high, so no false edge follows reset
         next_s = '1;
      end
   end

   always_ff @(posedge mclk) begin
      s <= next_s;
   end

   assign dout = s.stage2;

endmodule

// ===== hw/sib_pin_cfg.sv
`timescale 1ns/10ps

module sib_pin_cfg (
   // configuration
   input wire logic [3:0] cfg,
   input wire logic slowAll,
   // serial level to present
   input wire logic drive,
   // pad controls
   output logic pinOut,
   output logic pinOe,
   output logic pinSlow
);

   always_comb begin
      pinOut = 1'b0;
      pinOe = 1'b0;
      pinSlow = 1'b0;
      case (cfg)
         sib_pkg::SIB_PIN_OPEN: begin
            pinOe = 1'b0;
         end
         sib_pkg::SIB_PIN_CMOS: begin
            pinOut = drive;
            pinOe = 1'b1;
         end
         sib_pkg::SIB_PIN_SLOW: begin
            pinOut = drive;
            pinOe = 1'b1;
            pinSlow = 1'b1;
         end
         sib_pkg::SIB_PIN_OD: begin
            pinOe = ~drive;
         end
         default: begin
            pinOe = 1'b0;
         end
      endcase
      if (slowAll) begin
         pinSlow = 1'b1;
      end
   end

endmodule

// ===== hw/sib_top.sv
`timescale 1ns/10ps

// Behaviour
// - speed_select 1 gives 8x scl period multiplier, 0 gives 2x.
// - mode_select 1 is synchronous serial mode, 0 is I2C mode.
// - serial_data_buffer is an 8-bit read/write register for both directions.
// - I2C: receive shift register copied to buffer at 8th SCL falling edge.
// - sync mode: receive shift register copied to buffer at 8th rising edge.
// - I2C transmitter: transmit shift register loaded from buffer on start.
// - I2C transmitter: buffer write with transfer-end set loads transmit register.
// - sync mode: buffer write with master_active_flag clear loads transmit register.
// - threshold_select 1 gives CMOS input levels, 0 gives TTL levels.
// - slow_output_select 1 forces slow fall on clock and data pins.
// - clock pin codes: 1111 open, 1001 CMOS, 1110 slow, 1101 open drain.
// - data pin input always enabled; output follows the same four codes.
// - data_out_pin may be CMOS, slow CMOS or open drain for 3-wire.
module sib_top (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // control logic of the serial unit
   input wire logic masterActive,
   input wire logic transferEnd,
   input wire logic txEnable,
   input wire logic startDetected,
   input wire logic sclDrive,
   // clock_pin
   input wire logic clockPinIn,
   output logic clockPinOut,
   output logic clockPinOe,
   output logic clockPinSlow,
   // data_pin
   input wire logic dataPinIn,
   output logic dataPinOut,
   output logic dataPinOe,
   output logic dataPinSlow,
   // data_out_pin
   output logic dataOutPinOut,
   output logic dataOutPinOe,
   output logic dataOutPinSlow,
   // port and rate settings
   output logic cmosThreshold,
   output logic portVoltage5v,
   output logic sdaHoldAdjust,
   output logic syncMode,
   output logic [8:0] sclPeriod
);

   typedef struct packed {
      logic [7:0] dataBuf;
      logic [7:0] rxShift;
      logic [7:0] txShift;
      logic [3:0] bitCount;
      logic serialOut;
      logic [3:0] portCtrl;
      logic modeSel;
      logic speedSel;
      logic [4:0] sclDiv;
      logic [8:0] sclPeriod;
      logic [11:0] pinCfg;
      logic sclPrev;
      logic apValid;
      logic apWrite;
      logic [17:0] apAddr;
      logic [31:0] rdata;
   } sib_state_t;

   sib_state_t s;
   sib_state_t next_s;

   logic [1:0] pinSync;
   logic sclSync;
   logic sdaSync;
   logic sclRise;
   logic sclFall;
   logic wrPhase;
   logic bufWr;
   logic pcntWr;
   logic modeWr;
   logic pinsWr;
   logic midByte;

   sib_sync u_sync (
      .mclk(mclk),
      .rst_n(rst_n),
      .din({dataPinIn, clockPinIn}),
      .dout(pinSync)
   );

   assign sclSync = pinSync[0];
   assign sdaSync = pinSync[1];
   assign sclRise = sclSync & ~s.sclPrev;
   assign sclFall = ~sclSync & s.sclPrev;

   // data phase write strobes
   assign wrPhase = s.apValid & s.apWrite;
   assign bufWr = wrPhase & sib_pkg::regHit(s.apAddr, sib_pkg::SIB_IDX_BUF);
   assign pcntWr = wrPhase & sib_pkg::regHit(s.apAddr, sib_pkg::SIB_IDX_PCNT);
   assign modeWr = wrPhase & sib_pkg::regHit(s.apAddr, sib_pkg::SIB_IDX_MODE);
   assign pinsWr = wrPhase & sib_pkg::regHit(s.apAddr, sib_pkg::SIB_IDX_PINS);

   // i2c transmit shifts after falls one to eight, sync after falls one to seven; the eighth empties an i2c byte
   assign midByte = (s.bitCount != 4'h0) && (s.bitCount <= sib_pkg::SIB_BIT_BYTE);

   always_comb begin
      next_s = s;

      // address phase capture
      next_s.apValid = hsel & hready & htrans[1];
      next_s.apWrite = hwrite;
      next_s.apAddr = haddr[17:0];
      next_s.sclPrev = sclSync;

      // software writes
      if (bufWr) begin
         next_s.dataBuf = hwdata[7:0];
      end
      if (pcntWr) begin
         next_s.portCtrl = hwdata[3:0];
      end
      if (modeWr) begin
         next_s.modeSel = hwdata[sib_pkg::SIB_MODE_SEL];
         next_s.speedSel = hwdata[sib_pkg::SIB_MODE_SPEED];
         next_s.sclDiv = hwdata[sib_pkg::SIB_MODE_DIV_MSB:0];
      end
      if (pinsWr) begin
         next_s.pinCfg = hwdata[11:0];
      end

      // receive side: sample on every rise
      if (sclRise) begin
         next_s.rxShift = {s.rxShift[6:0], sdaSync};
         if (s.bitCount != sib_pkg::SIB_BIT_ACK) begin
            next_s.bitCount = s.bitCount + 4'h1;
         end
      end

      if (s.modeSel) begin
         // sync mode: byte ends on the eighth rise
         if (sclRise && s.bitCount == sib_pkg::SIB_BIT_LAST_RISE) begin
            next_s.dataBuf = {s.rxShift[6:0], sdaSync};
            next_s.bitCount = 4'h0;
         end
      end else begin
         // i2c: byte ends on the eighth fall, ack clock closes the frame
         if (sclFall && s.bitCount == sib_pkg::SIB_BIT_BYTE) begin
            next_s.dataBuf = s.rxShift;
         end
         if (sclFall && s.bitCount == sib_pkg::SIB_BIT_ACK) begin
            next_s.bitCount = 4'h0;
         end
         if (startDetected) begin
            next_s.bitCount = 4'h0;
         end
      end

      // transmit side
      if (sclFall && midByte) begin
         next_s.txShift = {s.txShift[6:0], 1'b1};
      end
      if (!s.modeSel && txEnable && startDetected) begin
         next_s.txShift = s.dataBuf;
      end
      if (bufWr && !s.modeSel && txEnable && transferEnd) begin
         next_s.txShift = hwdata[7:0];
      end
      if (bufWr && s.modeSel && !masterActive) begin
         next_s.txShift = hwdata[7:0];
      end

      // i2c releases data unless transmitting; shifted-in ones release it after the byte
      if (next_s.modeSel) begin
         next_s.serialOut = next_s.txShift[7];
      end else begin
         next_s.serialOut = ~txEnable | next_s.txShift[7];
      end

      // period in filter clocks
      next_s.sclPeriod = (9'(next_s.sclDiv) + 9'h001) *
                         (next_s.speedSel ? sib_pkg::SIB_MULT_STD : sib_pkg::SIB_MULT_FAST);

      // read data from the post-write view
      next_s.rdata = 32'h00000000;
      if (hsel && hready && htrans[1] && !hwrite) begin
         if (sib_pkg::regHit(haddr[17:0], sib_pkg::SIB_IDX_BUF)) begin
            next_s.rdata = {24'h000000, next_s.dataBuf};
         end else if (sib_pkg::regHit(haddr[17:0], sib_pkg::SIB_IDX_PCNT)) begin
            next_s.rdata = {28'h0000000, next_s.portCtrl};
         end else if (sib_pkg::regHit(haddr[17:0], sib_pkg::SIB_IDX_MODE)) begin
            next_s.rdata = {24'h000000, next_s.modeSel, 1'b0, next_s.speedSel, next_s.sclDiv};
         end else if (sib_pkg::regHit(haddr[17:0], sib_pkg::SIB_IDX_PINS)) begin
            next_s.rdata = {20'h00000, next_s.pinCfg};
         end else if (sib_pkg::regHit(haddr[17:0], sib_pkg::SIB_IDX_STAT)) begin
            next_s.rdata = {24'h000000, next_s.bitCount, sdaSync, sclSync, transferEnd,
                            masterActive};
         end
      end

      if (!rst_n) begin
         next_s = '0;
         next_s.dataBuf = sib_pkg::SIB_BUF_RST;
         next_s.portCtrl = sib_pkg::SIB_PCNT_RST;
         next_s.pinCfg = sib_pkg::SIB_PINS_RST;
         next_s.serialOut = 1'b1;
         next_s.sclPrev = 1'b1;
         next_s.sclPeriod = sib_pkg::SIB_MULT_FAST;
      end
   end

   always_ff @(posedge mclk) begin
      s <= next_s;
   end

   // pads
   sib_pin_cfg u_clock_pin (
      .cfg(s.pinCfg[sib_pkg::SIB_PIN_CLK_LSB +: 4]),
      .slowAll(s.portCtrl[sib_pkg::SIB_PC_SLOW]),
      .drive(sclDrive),
      .pinOut(clockPinOut),
      .pinOe(clockPinOe),
      .pinSlow(clockPinSlow)
   );

   sib_pin_cfg u_data_pin (
      .cfg(s.pinCfg[sib_pkg::SIB_PIN_DATA_LSB +: 4]),
      .slowAll(s.portCtrl[sib_pkg::SIB_PC_SLOW]),
      .drive(s.serialOut),
      .pinOut(dataPinOut),
      .pinOe(dataPinOe),
      .pinSlow(dataPinSlow)
   );

   sib_pin_cfg u_data_out_pin (
      .cfg(s.pinCfg[sib_pkg::SIB_PIN_DOUT_LSB +: 4]),
      .slowAll(1'b0),
      .drive(s.serialOut),
      .pinOut(dataOutPinOut),
      .pinOe(dataOutPinOe),
      .pinSlow(dataOutPinSlow)
   );

   // bus answers
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = s.rdata;

   assign cmosThreshold = s.portCtrl[sib_pkg::SIB_PC_THR];
   assign portVoltage5v = s.portCtrl[sib_pkg::SIB_PC_VOLT];
   assign sdaHoldAdjust = s.portCtrl[sib_pkg::SIB_PC_HOLD];
   assign syncMode = s.modeSel;
   assign sclPeriod = s.sclPeriod;

   default clocking cb @(posedge mclk);
   endclocking

   default disable iff (!rst_n);

   a_i2c_capture: assert property (
      (!s.modeSel && sclFall && s.bitCount == 4'h8) |=> s.dataBuf == $past(s.rxShift))
      else $error("i2c byte not captured on eighth fall");

   a_sync_capture: assert property (
      (s.modeSel && sclRise && s.bitCount == 4'h7)
      |=> (s.dataBuf == {$past(s.rxShift[6:0]), $past(sdaSync)}) && s.bitCount == 4'h0)
      else $error("sync byte not captured on eighth rise");

   a_start_load: assert property (
      (!s.modeSel && txEnable && startDetected && !bufWr) |=> s.txShift == $past(s.dataBuf))
      else $error("start did not load transmit register");

   a_end_load: assert property (
      (bufWr && !s.modeSel && txEnable && transferEnd) |=> s.txShift == $past(hwdata[7:0]))
      else $error("buffer write at transfer end did not load");

   a_sync_load: assert property (
      (bufWr && s.modeSel && !masterActive) |=> s.txShift == $past(hwdata[7:0]))
      else $error("sync buffer write did not load");

   a_scl_mult: assert property (
      modeWr |=> ##1 sclPeriod == (9'($past(hwdata[4:0], 2)) + 9'h001) *
                 ($past(hwdata[5], 2) ? 9'h008 : 9'h002))
      else $error("scl period multiplier wrong");

   a_threshold_follow: assert property (
      pcntWr |=> cmosThreshold == $past(hwdata[1]))
      else $error("threshold select not applied");

   a_slow_pins: assert property (
      s.portCtrl[0] |-> clockPinSlow && dataPinSlow)
      else $error("slow output not forced");

   a_scl_drain: assert property (
      (s.pinCfg[3:0] == 4'hd) |-> !clockPinOut && (clockPinOe == !sclDrive))
      else $error("clock pin not open drain");

   a_buf_read: assert property (
      (s.apValid && !s.apWrite && sib_pkg::regHit(s.apAddr, sib_pkg::SIB_IDX_BUF))
      |-> hrdata[7:0] == s.dataBuf)
      else $error("buffer read mismatch");

   a_clock_open: assert property (
      (s.pinCfg[3:0] == 4'hf) |-> !clockPinOe)
      else $error("clock pin not open");

   a_clock_cmos: assert property (
      (s.pinCfg[3:0] == 4'h9) |-> clockPinOe && (clockPinOut == sclDrive))
      else $error("clock pin not cmos");

   a_data_drain: assert property (
      (s.pinCfg[7:4] == 4'hd) |-> !dataPinOut && (dataPinOe == !s.serialOut))
      else $error("data pin not open drain");

   a_dout_slow: assert property (
      (s.pinCfg[11:8] == 4'he) |-> dataOutPinOe && dataOutPinSlow)
      else $error("data output pin not slow cmos");

   a_mode_follow: assert property (
      modeWr |=> syncMode == $past(hwdata[7]))
      else $error("mode select not applied");

   c_i2c_byte: cover property (!s.modeSel && sclFall && s.bitCount == 4'h8);
   c_sync_byte: cover property (s.modeSel && sclRise && s.bitCount == 4'h7);
   c_start_load: cover property (!s.modeSel && txEnable && startDetected);
   c_sync_load: cover property (bufWr && s.modeSel && !masterActive);
   c_end_load: cover property (bufWr && !s.modeSel && txEnable && transferEnd);

endmodule

// ===== tb/sib_peer.sv
`timescale 1ns/10ps

module sib_peer (
   // line seen by the peer
   input wire logic rx,
   // lines driven by the peer, released high
   output logic scl,
   output logic sda
);
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end

   // data set while scl low, sampled at end of high
   task automatic bitx(input logic v, input logic drop, output logic s);
      sda = v;
      #200 scl = 1'b1;
      #200 s = rx;
      if (drop) begin
         scl = 1'b0;
      end
   endtask

   task automatic lower();
      #200 scl = 1'b0;
   endtask

   task automatic start();
      sda = 1'b0;
      #200 scl = 1'b0;
   endtask

   task automatic stop();
      sda = 1'b0;
      #200 scl = 1'b1;
      #200 sda = 1'b1;
   endtask

   // msb first, eighth clock left high
   task automatic frame(input logic [7:0] tx, output logic [7:0] got);
      for (int i = 7; i >= 0; i--) begin
         bitx(tx[i], i > 0, got[i]);
      end
   endtask
endmodule

// ===== tb/sib_top_tb.sv
`timescale 1ns/10ps

module sib_top_tb;
   localparam logic [15:0] idxBuf = sib_pkg::SIB_IDX_BUF;
   localparam logic [15:0] idxPcnt = sib_pkg::SIB_IDX_PCNT;
   localparam logic [15:0] idxMode = sib_pkg::SIB_IDX_MODE;
   localparam logic [15:0] idxPins = sib_pkg::SIB_IDX_PINS;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic masterActive = 1'b0;
   logic transferEnd = 1'b0;
   logic txEnable = 1'b0;
   logic startDetected = 1'b0;
   logic sclDrive = 1'b1;
   logic hreadyout, hresp, clockPinOut, clockPinOe, clockPinSlow;
   logic dataPinOut, dataPinOe, dataPinSlow, dataOutPinOut, dataOutPinOe, dataOutPinSlow;
   logic cmosThreshold, portVoltage5v, sdaHoldAdjust, syncMode, peerScl, peerSda;
   logic [8:0] sclPeriod;
   logic [31:0] hrdata;
   int fails = 0;
   int checks = 0;
   // open-drain lines with pull-ups
   wire logic sclLine = peerScl & !(clockPinOe & !clockPinOut);
   wire logic sdaLine = peerSda & !(dataPinOe & !dataPinOut);
   wire logic rxLine = dataOutPinOe ? dataOutPinOut : sdaLine;

   always #25 mclk = ~mclk;

   sib_top dut (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .masterActive(masterActive),
      .transferEnd(transferEnd), .txEnable(txEnable), .startDetected(startDetected),
      .sclDrive(sclDrive), .clockPinIn(sclLine), .clockPinOut(clockPinOut),
      .clockPinOe(clockPinOe), .clockPinSlow(clockPinSlow), .dataPinIn(sdaLine),
      .dataPinOut(dataPinOut), .dataPinOe(dataPinOe), .dataPinSlow(dataPinSlow),
      .dataOutPinOut(dataOutPinOut), .dataOutPinOe(dataOutPinOe),
      .dataOutPinSlow(dataOutPinSlow), .cmosThreshold(cmosThreshold),
      .portVoltage5v(portVoltage5v), .sdaHoldAdjust(sdaHoldAdjust), .syncMode(syncMode),
      .sclPeriod(sclPeriod));

   sib_peer peer (.rx(rxLine), .scl(peerScl), .sda(peerSda));

   task automatic print_verdict();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic waitRdy();
      int n;
      n = 0;
      @(posedge mclk);
      while (hreadyout !== 1'b1 && n < 64) begin
         @(posedge mclk);
         n++;
      end
      if (n == 64) begin
         fails++;
         print_verdict();
      end
   endtask

   task automatic ahb(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
         output logic [31:0] rdat);
      @(posedge mclk);
      hsel <= 1'b1;
      haddr <= {14'h0, idx, 2'b00};
      htrans <= 2'h2;
      hwrite <= wr;
      waitRdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      waitRdy();
      rdat = hrdata;
   endtask

   task automatic wr(input logic [15:0] idx, input logic [31:0] wd);
      logic [31:0] d;
      ahb(1'b1, idx, wd, d);
   endtask

   task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp);
      logic [31:0] d;
      ahb(1'b0, idx, 32'h0, d);
      chk(d, exp);
   endtask

   task automatic settle();
      repeat (2) @(posedge mclk);
      #1;
   endtask

   task automatic s_reset();
      rdchk(idxBuf, 32'h0);
      rdchk(idxPcnt, 32'h0);
      rdchk(16'h0010, 32'h0);
      chk(hresp, 32'h0);
      chk(clockPinOe, 32'h0);
      chk(syncMode, 32'h0);
      chk(sclPeriod, 32'h2);
   endtask

   task automatic s_regs();
      wr(idxBuf, 32'ha5);
      rdchk(idxBuf, 32'ha5);
      wr(idxPcnt, 32'hf);
      rdchk(idxPcnt, 32'hf);
      settle();
      chk({cmosThreshold, portVoltage5v, sdaHoldAdjust}, 32'h7);
      wr(idxPcnt, 32'h0);
      settle();
      chk(cmosThreshold, 32'h0);
   endtask

   task automatic s_pins();
      logic [3:0] code [4];
      logic [3:0] oeExp;
      logic [3:0] slowExp;
      code = '{4'hf, 4'h9, 4'he, 4'hd};
      oeExp = 4'b0110;
      slowExp = 4'b0100;
      for (int i = 0; i < 4; i++) begin
         wr(idxPins, {20'h0, code[i], code[i], code[i]});
         settle();
         chk({clockPinOe, dataPinOe, dataOutPinOe}, {3{oeExp[i]}});
         chk({clockPinSlow, dataPinSlow, dataOutPinSlow}, {3{slowExp[i]}});
      end
      wr(idxPins, 32'h999);
      wr(idxPcnt, 32'h3);
      settle();
      chk({clockPinSlow, dataPinSlow, dataOutPinSlow}, 32'h6);
      chk({clockPinOut, dataPinOut, dataOutPinOut}, 32'h7);
      wr(idxPcnt, 32'h2);
      settle();
      chk({clockPinOut, clockPinSlow}, 32'h2);
   endtask

   task automatic s_rate();
      int d;
      for (int sp = 0; sp < 2; sp++) begin
         for (int k = 0; k < 2; k++) begin
            d = k ? 31 : 4;
            wr(idxMode, {24'h0, 2'b00, sp[0], d[4:0]});
            settle();
            chk(sclPeriod, (d + 1) * (sp ? 8 : 2));
            chk(syncMode, 32'h0);
         end
      end
      wr(idxMode, 32'h84);
      settle();
      chk(syncMode, 32'h1);
   endtask

   task automatic s_i2c_rx();
      logic [7:0] got;
      logic b;
      wr(idxMode, 32'h04);
      wr(idxPcnt, 32'h2);
      wr(idxPins, 32'hfdd);
      wr(idxBuf, 32'h11);
      peer.start();
      peer.frame(8'h3c, got);
      rdchk(idxBuf, 32'h11);
      peer.lower();
      repeat (4) @(posedge mclk);
      rdchk(idxBuf, 32'h3c);
      peer.bitx(1'b1, 1'b1, b);
      peer.stop();
   endtask

   task automatic s_i2c_tx();
      logic [7:0] got;
      logic b;
      @(posedge mclk);
      txEnable <= 1'b1;
      wr(idxBuf, 32'h96);
      peer.start();
      @(posedge mclk);
      startDetected <= 1'b1;
      @(posedge mclk);
      startDetected <= 1'b0;
      peer.frame(8'hff, got);
      chk(got, 32'h96);
      peer.lower();
      repeat (4) @(posedge mclk);
      rdchk(idxBuf, 32'h96);
      peer.bitx(1'b1, 1'b1, b);
      @(posedge mclk);
      transferEnd <= 1'b1;
      wr(idxBuf, 32'h5a);
      transferEnd <= 1'b0;
      peer.frame(8'hff, got);
      chk(got, 32'h5a);
      peer.lower();
      peer.bitx(1'b1, 1'b1, b);
      txEnable <= 1'b0;
      peer.stop();
   endtask

   // clock pin pulled by the rate side, then a reset in mid-run restores the register reset values
   task automatic s_midreset();
      @(posedge mclk);
      sclDrive <= 1'b0;
      settle();
      chk({clockPinOut, clockPinOe}, 32'h1);
      @(posedge mclk);
      sclDrive <= 1'b1;
      settle();
      chk(clockPinOe, 32'h0);
      @(posedge mclk);
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      s_reset();
   endtask

   task automatic s_sync();
      logic [7:0] got;
      wr(idxMode, 32'ha4);
      wr(idxPins, 32'h9ff);
      wr(idxBuf, 32'hc3);
      peer.lower();
      peer.frame(8'h71, got);
      repeat (4) @(posedge mclk);
      rdchk(idxBuf, 32'h71);
      chk(got, 32'hc3);
   endtask

   initial begin
      #3000000;
      fails++;
      print_verdict();
   end

   initial begin
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      s_reset();
      s_regs();
      s_pins();
      s_rate();
      s_i2c_rx();
      s_i2c_tx();
      s_midreset();
      s_sync();
      print_verdict();
   end
endmodule
